/* verilog/oscsw_ctrl.sv */
// Oscillator control registers and clock switch sequencer
`timescale 1ns/1ps
`default_nettype none
module oscsw_ctrl (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // Configuration straps
    input wire logic switch_enable_config,
    input wire logic lock_enable_config,
    input wire logic [2:0] initial_source_config,
    input wire logic watchdog_enable,
    // Analog side status
    input wire logic osc_startup_done,
    input wire logic pll_locked,
    input wire logic new_clk_tick,
    input wire logic clock_fail_event,
    input wire logic irq_event,
    // Clock tree controls
    output oscsw_pkg::oscsw_osc_en_s osc_en,
    output oscsw_pkg::oscsw_div_s div_cfg,
    output logic [2:0] sys_clk_sel,
    output logic switch_busy
);
    import oscsw_pkg::*;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [2:0] cur_src_r;
    logic [2:0] new_src_r;
    logic [2:0] tgt_src_r;
    logic switch_request_r;
    logic secondary_osc_enable_r;
    logic clock_config_lock_r;
    logic clock_fail_flag_r;
    logic pll_lock_r;
    logic [15:0] clk_div_r;
    logic [8:0] pll_fbd_r;
    logic [5:0] rc_trim_r;
    logic [1:0] key_lo_r;
    logic [1:0] key_hi_r;
    logic [3:0] settle_r;
    logic strap_done_r;
    logic switch_on_r;
    oscsw_state_e state_r;

    logic key_wr;
    logic ctrl_wr;
    logic lo_open;
    logic hi_open;
    logic cfg_locked;
    logic tgt_pll;
    logic tgt_xtal;
    logic ready;

    assign key_wr = wr && (addr == OSCSW_ADDR_UNLOCK);
    assign ctrl_wr = wr && (addr == OSCSW_ADDR_OSC_CTRL);
    assign lo_open = key_lo_r == 2'h2;
    assign hi_open = key_hi_r == 2'h2;
    assign cfg_locked = clock_config_lock_r && lock_enable_config;
    assign tgt_pll = (tgt_src_r == OSCSW_SRC_RC_PLL) || (tgt_src_r == OSCSW_SRC_PRI_PLL);
    assign tgt_xtal = (tgt_src_r == OSCSW_SRC_PRI) || (tgt_src_r == OSCSW_SRC_PRI_PLL);
    assign ready = (!tgt_xtal || osc_startup_done) && (!tgt_pll || pll_locked);
    assign switch_busy = state_r != OSCSW_IDLE;

    // ----------------------------------------------------------------
    // Configuration straps
    // ----------------------------------------------------------------
    // Straps are caught on the first clocked cycle after reset release
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            strap_done_r <= 1'b0;
            switch_on_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            switch_on_r <= !switch_enable_config;
        end
    end

    // ----------------------------------------------------------------
    // Unlock sequence
    // ----------------------------------------------------------------
    // Each window grants one write to its byte; any other key write restarts it
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            key_lo_r <= 2'h0;
            key_hi_r <= 2'h0;
        end else begin
            if (key_wr && wdata == OSCSW_KEY_LO_1) begin
                key_lo_r <= 2'h1;
            end else if (key_wr && wdata == OSCSW_KEY_LO_2 && key_lo_r == 2'h1) begin
                key_lo_r <= 2'h2;
            end else if (key_wr || (ctrl_wr && lo_open)) begin
                key_lo_r <= 2'h0;
            end
            if (key_wr && wdata == OSCSW_KEY_HI_1) begin
                key_hi_r <= 2'h1;
            end else if (key_wr && wdata == OSCSW_KEY_HI_2 && key_hi_r == 2'h1) begin
                key_hi_r <= 2'h2;
            end else if (key_wr || (ctrl_wr && hi_open)) begin
                key_hi_r <= 2'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Oscillator control register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            new_src_r <= OSCSW_SRC_RC_DIVN;
            secondary_osc_enable_r <= 1'b0;
            clock_config_lock_r <= 1'b0;
        end else if (!strap_done_r) begin
            new_src_r <= initial_source_config;
        end else if (ctrl_wr) begin
            if (hi_open && !cfg_locked) begin
                new_src_r <= wdata[OSCSW_POS_NEW +: 3];
            end
            if (lo_open) begin
                secondary_osc_enable_r <= wdata[OSCSW_BIT_SEC_EN];
                clock_config_lock_r <= wdata[OSCSW_BIT_CLKLCK] | clock_config_lock_r;
            end
        end
    end

    // Hardware set of the fail flag wins over a software clear
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            clock_fail_flag_r <= 1'b0;
        end else if (clock_fail_event && switch_on_r) begin
            clock_fail_flag_r <= 1'b1;
        end else if (state_r == OSCSW_START) begin
            clock_fail_flag_r <= 1'b0;
        end else if (ctrl_wr && lo_open && !wdata[OSCSW_BIT_FAIL]) begin
            clock_fail_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pll_lock_r <= 1'b0;
        end else if (state_r == OSCSW_START) begin
            pll_lock_r <= 1'b0;
        end else begin
            pll_lock_r <= pll_locked;
        end
    end

    // ----------------------------------------------------------------
    // Switch sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_r <= OSCSW_IDLE;
            switch_request_r <= 1'b0;
            cur_src_r <= OSCSW_SRC_RC_DIVN;
            tgt_src_r <= OSCSW_SRC_RC_DIVN;
            settle_r <= 4'h0;
        end else if (!strap_done_r) begin
            cur_src_r <= initial_source_config;
            tgt_src_r <= initial_source_config;
        end else begin
            unique case (state_r)
                OSCSW_IDLE: begin
                    if (ctrl_wr && lo_open && wdata[OSCSW_BIT_REQ] && switch_on_r && !cfg_locked) begin
                        if (new_src_r == cur_src_r) begin
                            switch_request_r <= 1'b0;
                        end else begin
                            switch_request_r <= 1'b1;
                            tgt_src_r <= new_src_r;
                            state_r <= OSCSW_START;
                        end
                    end else begin
                        switch_request_r <= 1'b0;
                    end
                end
                OSCSW_START: begin
                    state_r <= OSCSW_WAIT_RDY;
                end
                OSCSW_WAIT_RDY: begin
                    settle_r <= 4'h0;
                    if (ready) begin
                        state_r <= OSCSW_SETTLE;
                    end
                end
                OSCSW_SETTLE: begin
                    if (new_clk_tick) begin
                        settle_r <= settle_r + 4'h1;
                        if (settle_r == OSCSW_SETTLE_CYC - 4'h1) begin
                            state_r <= OSCSW_DONE;
                        end
                    end
                end
                OSCSW_DONE: begin
                    cur_src_r <= tgt_src_r;
                    switch_request_r <= 1'b0;
                    state_r <= OSCSW_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Divisor, feedback and trim registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            clk_div_r <= OSCSW_RST_CLK_DIV;
        end else if (irq_event && clk_div_r[OSCSW_BIT_ROI]) begin
            clk_div_r[OSCSW_BIT_SLOW_EN] <= 1'b0;
        end else if (wr && addr == OSCSW_ADDR_CLK_DIV) begin
            clk_div_r[15:8] <= wdata[15:8];
            if (!cfg_locked) begin
                clk_div_r[7:0] <= {wdata[7:6], 1'b0, wdata[4:0]};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pll_fbd_r <= OSCSW_RST_PLL_FBD;
        end else if (wr && addr == OSCSW_ADDR_PLL_FBD && !cfg_locked) begin
            pll_fbd_r <= wdata[8:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rc_trim_r <= OSCSW_RST_RC_TRIM;
        end else if (wr && addr == OSCSW_ADDR_RC_TRIM) begin
            rc_trim_r <= wdata[5:0];
        end
    end

    // ----------------------------------------------------------------
    // Clock tree controls
    // ----------------------------------------------------------------
    logic [3:0] post_div_nxt;
    always_comb begin
        unique case (clk_div_r[OSCSW_POS_POST +: 2])
            2'h0: post_div_nxt = 4'h2;
            2'h1: post_div_nxt = 4'h4;
            2'h3: post_div_nxt = 4'h8;
            // Reserved code keeps the slowest safe output
            default: post_div_nxt = 4'h8;
        endcase
    end

    logic src_rc;
    assign src_rc = (tgt_src_r == OSCSW_SRC_RC) || (tgt_src_r == OSCSW_SRC_RC_PLL) ||
                    (tgt_src_r == OSCSW_SRC_RC_DIV16) || (tgt_src_r == OSCSW_SRC_RC_DIVN) ||
                    (cur_src_r == OSCSW_SRC_RC) || (cur_src_r == OSCSW_SRC_RC_PLL) ||
                    (cur_src_r == OSCSW_SRC_RC_DIV16) || (cur_src_r == OSCSW_SRC_RC_DIVN);

    // During a switch both old and new sources run; afterwards tgt equals cur
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            osc_en <= '0;
            div_cfg <= '0;
            sys_clk_sel <= OSCSW_SRC_RC_DIVN;
        end else begin
            osc_en.rc_on <= src_rc;
            osc_en.pri_on <= (tgt_src_r == OSCSW_SRC_PRI) || (tgt_src_r == OSCSW_SRC_PRI_PLL) ||
                             (cur_src_r == OSCSW_SRC_PRI) || (cur_src_r == OSCSW_SRC_PRI_PLL);
            osc_en.sec_on <= secondary_osc_enable_r || tgt_src_r == OSCSW_SRC_SEC ||
                             cur_src_r == OSCSW_SRC_SEC;
            osc_en.low_power_rc_oscillator_on <= watchdog_enable || switch_on_r || tgt_src_r == OSCSW_SRC_LOW_POWER_RC_OSCILLATOR ||
                              cur_src_r == OSCSW_SRC_LOW_POWER_RC_OSCILLATOR;
            osc_en.pll_on <= tgt_pll || cur_src_r == OSCSW_SRC_RC_PLL || cur_src_r == OSCSW_SRC_PRI_PLL;
            div_cfg.slow_div <= clk_div_r[OSCSW_BIT_SLOW_EN] ?
                8'h01 << clk_div_r[OSCSW_POS_SLOW +: 3] : 8'h01;
            div_cfg.rc_div <= (clk_div_r[OSCSW_POS_RCDIV +: 3] == 3'h7) ?
                9'h100 : 9'h001 << clk_div_r[OSCSW_POS_RCDIV +: 3];
            div_cfg.post_div <= post_div_nxt;
            div_cfg.pre_div <= {1'b0, clk_div_r[OSCSW_POS_PRE +: 5]} + 6'h02;
            div_cfg.pll_mult <= {1'b0, pll_fbd_r} + 10'h002;
            div_cfg.rc_trim_value <= rc_trim_r;
            sys_clk_sel <= cur_src_r;
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            unique case (addr)
                OSCSW_ADDR_OSC_CTRL: rdata <= {1'b0, cur_src_r, 1'b0, new_src_r, clock_config_lock_r, 1'b0,
                                               pll_lock_r, 1'b0, clock_fail_flag_r, 1'b0,
                                               secondary_osc_enable_r, switch_request_r};
                OSCSW_ADDR_CLK_DIV: rdata <= clk_div_r;
                OSCSW_ADDR_PLL_FBD: rdata <= {7'h00, pll_fbd_r};
                OSCSW_ADDR_RC_TRIM: rdata <= {10'h000, rc_trim_r};
                default: rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

endmodule
`default_nettype wire

/* verilog/oscsw_pkg.sv */
// Constants and types for the oscillator control and clock switch block
// Contract
// - Secondary oscillator enable bit drives secondary oscillator
// - Switch request starts switch, reads zero after
// - Control register writes need unlock first
// - Recover-on-interrupt clears slowdown enable on interrupt
// - Slowdown ratio divides by 1 to 128
// - Slowdown enable selects ratio, else 1:1
// - RC postscaler divides 1..64, code 7 by 256
// - PLL output divider 2/4/8, code 10 reserved
// - PLL prescaler divides by field plus two
// - PLL multiplier is field plus two
// - RC trim is two's complement, reset zero
// - Switching only when switch config is zero
// - Disabled: current source follows initial config
// - Disabled: switch request held at zero
// - Equal sources: clear request, abort switch
// - Valid switch start clears lock and fail flags
// - Start new oscillator, wait timer and lock
// - Count ten new-clock cycles before switching
// - Completion clears request, copies new source
// - Turn off old source with keep-alive exceptions
// - Source codes: RC, RC+PLL, primary, ... divN
// - Clock lock bit with config locks settings
// - Fail flag set on failure only while switching is enabled, cleared by write
package oscsw_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] OSCSW_ADDR_OSC_CTRL = 4'h0;
    localparam logic [3:0] OSCSW_ADDR_CLK_DIV = 4'h1;
    localparam logic [3:0] OSCSW_ADDR_PLL_FBD = 4'h2;
    localparam logic [3:0] OSCSW_ADDR_RC_TRIM = 4'h3;
    localparam logic [3:0] OSCSW_ADDR_UNLOCK = 4'h4;

    localparam int OSCSW_BIT_REQ = 0;
    localparam int OSCSW_BIT_SEC_EN = 1;
    localparam int OSCSW_BIT_FAIL = 3;
    localparam int OSCSW_BIT_LOCK = 5;
    localparam int OSCSW_BIT_CLKLCK = 7;
    localparam int OSCSW_POS_NEW = 8;
    localparam int OSCSW_POS_CUR = 12;
    localparam int OSCSW_POS_PRE = 0;
    localparam int OSCSW_POS_POST = 6;
    localparam int OSCSW_POS_RCDIV = 8;
    localparam int OSCSW_BIT_SLOW_EN = 11;
    localparam int OSCSW_POS_SLOW = 12;
    localparam int OSCSW_BIT_ROI = 15;

    localparam logic [15:0] OSCSW_RST_CLK_DIV = 16'h3040;
    localparam logic [8:0] OSCSW_RST_PLL_FBD = 9'h030;
    localparam logic [5:0] OSCSW_RST_RC_TRIM = 6'h00;

    // Unlock keys written in order to the unlock address
    localparam logic [15:0] OSCSW_KEY_LO_1 = 16'h0046;
    localparam logic [15:0] OSCSW_KEY_LO_2 = 16'h0057;
    localparam logic [15:0] OSCSW_KEY_HI_1 = 16'h0078;
    localparam logic [15:0] OSCSW_KEY_HI_2 = 16'h009A;

    // Settle count on the new clock before the handover
    localparam logic [3:0] OSCSW_SETTLE_CYC = 4'hA;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OSCSW_SRC_RC = 3'h0,
        OSCSW_SRC_RC_PLL = 3'h1,
        OSCSW_SRC_PRI = 3'h2,
        OSCSW_SRC_PRI_PLL = 3'h3,
        OSCSW_SRC_SEC = 3'h4,
        OSCSW_SRC_LOW_POWER_RC_OSCILLATOR = 3'h5,
        OSCSW_SRC_RC_DIV16 = 3'h6,
        OSCSW_SRC_RC_DIVN = 3'h7
    } oscsw_src_e;

    typedef enum logic [4:0] {
        OSCSW_IDLE = 5'b00001,
        OSCSW_START = 5'b00010,
        OSCSW_WAIT_RDY = 5'b00100,
        OSCSW_SETTLE = 5'b01000,
        OSCSW_DONE = 5'b10000
    } oscsw_state_e;

    // Per-source oscillator enables toward the analog block
    typedef struct packed {
        logic rc_on;
        logic pri_on;
        logic sec_on;
        logic low_power_rc_oscillator_on;
        logic pll_on;
    } oscsw_osc_en_s;

    // Divider settings toward the clock tree
    typedef struct packed {
        logic [7:0] slow_div;
        logic [8:0] rc_div;
        logic [3:0] post_div;
        logic [5:0] pre_div;
        logic [9:0] pll_mult;
        logic signed [5:0] rc_trim_value;
    } oscsw_div_s;

endpackage

/* verification/oscsw_ctrl_props.sv */
// Concurrent checks on the ports of the oscillator control and clock switch block
`timescale 1ns/1ps
`default_nettype none
module oscsw_ctrl_props (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port and straps
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic switch_enable_config,
    input wire logic [2:0] initial_source_config,
    input wire logic watchdog_enable,
    input wire logic new_clk_tick,
    input wire logic irq_event,
    // Clock tree controls
    input wire oscsw_pkg::oscsw_osc_en_s osc_en,
    input wire oscsw_pkg::oscsw_div_s div_cfg,
    input wire logic [2:0] sys_clk_sel,
    input wire logic switch_busy
);
    import oscsw_pkg::*;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Straps land two edges after release, so wait three before judging outputs
    logic [1:0] up_r;
    logic [7:0] tick_r;
    wire logic warm = (up_r == 2'h3);
    always_ff @(posedge ref_clk) begin
        if (!nrst) up_r <= 2'h0;
        else if (up_r != 2'h3) up_r <= up_r + 2'h1;
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst || !switch_busy) tick_r <= 8'h00;
        else if (new_clk_tick && tick_r != 8'hFF) tick_r <= tick_r + 8'h01;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_rdata_idle_zero: assert property (warm && !$past(rd) |-> rdata == 16'h0000)
        else $error("read data not zero outside read answer");
    chk_slow_power_two: assert property (warm |-> $onehot(div_cfg.slow_div))
        else $error("slowdown divide not a power of two");
    chk_rc_div_set: assert property (warm |-> $onehot(div_cfg.rc_div) && div_cfg.rc_div != 9'h080)
        else $error("rc postscaler divide out of set");
    chk_post_div_set: assert property (warm |-> div_cfg.post_div inside {4'h2, 4'h4, 4'h8})
        else $error("pll output divide out of set");
    chk_disabled_no_busy: assert property (warm && switch_enable_config |-> !switch_busy)
        else $error("sequencer ran with switching disabled");
    chk_disabled_sel_strap: assert property (warm && switch_enable_config |->
        sys_clk_sel == initial_source_config)
        else $error("selected source differs from strap");
    chk_low_power_rc_oscillator_kept_on: assert property (warm && $past(watchdog_enable) |-> osc_en.low_power_rc_oscillator_on)
        else $error("low power rc stopped while watchdog on");
    chk_ten_ticks_seen: assert property (warm && $fell(switch_busy) |-> tick_r >= 8'h0A)
        else $error("switch finished before ten new clock cycles");
    // Selection moves exactly one cycle after the sequencer drops busy
    chk_sel_quiet_busy: assert property (warm && $changed(sys_clk_sel) |->
        $past(switch_busy, 2) && !$past(switch_busy))
        else $error("selected source moved mid switch");
    // ------------------------------------------------------------
    // Covers
    // ------------------------------------------------------------
    cover property ($fell(switch_busy));
    cover property (irq_event);
    cover property (rd ##1 rdata != 16'h0000);
endmodule
bind oscsw_ctrl oscsw_ctrl_props u_props (.ref_clk(ref_clk), .nrst(nrst), .rd(rd), .rdata(rdata),
    .switch_enable_config(switch_enable_config), .initial_source_config(initial_source_config),
    .watchdog_enable(watchdog_enable), .new_clk_tick(new_clk_tick), .irq_event(irq_event),
    .osc_en(osc_en), .div_cfg(div_cfg), .sys_clk_sel(sys_clk_sel), .switch_busy(switch_busy));
`default_nettype wire

/* verification/oscsw_ctrl_bench.sv */
// Self-checking bench for the oscillator control and clock switch block
`timescale 1ns/1ps
`default_nettype none
module oscsw_ctrl_bench;
    import oscsw_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sw_cfg = 1'b0;
    logic lk_cfg = 1'b1;
    logic [2:0] init_src = 3'h0;
    logic wdt_en = 1'b1;
    logic ost_done = 1'b0;
    logic pll_lk = 1'b0;
    logic tick = 1'b0;
    logic fail_ev = 1'b0;
    logic irq = 1'b0;
    logic [15:0] rdata;
    oscsw_osc_en_s osc_en;
    oscsw_div_s div_cfg;
    logic [2:0] sys_clk_sel;
    logic switch_busy;
    logic [15:0] v;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    always #2.5 ref_clk = ~ref_clk;
    oscsw_ctrl dut (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .switch_enable_config(sw_cfg), .lock_enable_config(lk_cfg),
        .initial_source_config(init_src), .watchdog_enable(wdt_en), .osc_startup_done(ost_done),
        .pll_locked(pll_lk), .new_clk_tick(tick), .clock_fail_event(fail_ev), .irq_event(irq),
        .osc_en(osc_en), .div_cfg(div_cfg), .sys_clk_sel(sys_clk_sel), .switch_busy(switch_busy));
    // ------------------------------------------------------------
    // Bus and helper tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks=%0d errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Whole run is a few hundred cycles; a hang trips this ceiling
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic osc_wr(input logic hi, input logic [15:0] d);
        wr_reg(OSCSW_ADDR_UNLOCK, hi ? OSCSW_KEY_HI_1 : OSCSW_KEY_LO_1);
        wr_reg(OSCSW_ADDR_UNLOCK, hi ? OSCSW_KEY_HI_2 : OSCSW_KEY_LO_2);
        wr_reg(OSCSW_ADDR_OSC_CTRL, d);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            tick <= 1'b1;
            @(posedge ref_clk);
            tick <= 1'b0;
        end
        wait_n(2);
    endtask
    task automatic do_reset(input logic sw, input logic [2:0] src);
        @(posedge ref_clk);
        nrst <= 1'b0;
        sw_cfg <= sw;
        init_src <= src;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        wait_n(3);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd_reg(OSCSW_ADDR_CLK_DIV); chk(v, 16'h3040);
        rd_reg(OSCSW_ADDR_PLL_FBD); chk(v, 16'h0030);
        rd_reg(OSCSW_ADDR_RC_TRIM); chk(v, 16'h0000);
        rd_reg(OSCSW_ADDR_OSC_CTRL); chk(v & 16'h77AB, 16'h0000);
        chk({8'h00, div_cfg.slow_div}, 16'h0001);
        chk({7'h00, div_cfg.rc_div}, 16'h0001);
        chk({12'h000, div_cfg.post_div}, 16'h0004);
        chk({10'h000, div_cfg.pre_div}, 16'h0002);
        chk({6'h00, div_cfg.pll_mult}, 16'h0032);
        chk({10'h000, div_cfg.rc_trim_value}, 16'h0000);
        wr_reg(4'h5, 16'hFFFF);
        rd_reg(4'h5); chk(v, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_div();
        logic [15:0] w;
        for (int i = 0; i < 8; i++) begin
            w = {1'b0, i[2:0], 1'b1, i[2:0], i[1:0], 1'b0, i[2:0], 2'b11};
            wr_reg(OSCSW_ADDR_CLK_DIV, w);
            wait_n(3);
            chk({8'h00, div_cfg.slow_div}, 16'h0001 << i);
            chk({7'h00, div_cfg.rc_div}, (i == 7) ? 16'h0100 : (16'h0001 << i));
            chk({12'h000, div_cfg.post_div}, (i % 4 == 0) ? 16'h0002 : (i % 4 == 1) ? 16'h0004 : 16'h0008);
            chk({10'h000, div_cfg.pre_div}, {11'h000, i[2:0], 2'b11} + 16'h0002);
            rd_reg(OSCSW_ADDR_CLK_DIV); chk(v, w);
        end
        wr_reg(OSCSW_ADDR_CLK_DIV, 16'h7000);
        wait_n(3); chk({8'h00, div_cfg.slow_div}, 16'h0001);
        wr_reg(OSCSW_ADDR_PLL_FBD, 16'hFFFF);
        rd_reg(OSCSW_ADDR_PLL_FBD); chk(v, 16'h01FF);
        wait_n(2); chk({6'h00, div_cfg.pll_mult}, 16'h0201);
        wr_reg(OSCSW_ADDR_RC_TRIM, 16'hFFE0);
        rd_reg(OSCSW_ADDR_RC_TRIM); chk(v, 16'h0020);
        wait_n(2); chk({10'h000, div_cfg.rc_trim_value}, 16'h0020);
        $display("test dividers done");
    endtask
    task automatic t_roi(input logic [15:0] w, input logic [15:0] exp);
        wr_reg(OSCSW_ADDR_CLK_DIV, w);
        wait_n(3); chk({8'h00, div_cfg.slow_div}, 16'h0008);
        irq <= 1'b1;
        wait_n(1);
        irq <= 1'b0;
        wait_n(3); chk({8'h00, div_cfg.slow_div}, exp);
        $display("test interrupt recovery done");
    endtask
    task automatic t_unlock();
        wr_reg(OSCSW_ADDR_OSC_CTRL, 16'h0002);
        rd_reg(OSCSW_ADDR_OSC_CTRL); chk(v & 16'h0002, 16'h0000);
        osc_wr(1'b0, 16'h0002);
        wait_n(3); chk({15'h0000, osc_en.sec_on}, 16'h0001);
        wr_reg(OSCSW_ADDR_OSC_CTRL, 16'h0000);
        wr_reg(OSCSW_ADDR_UNLOCK, OSCSW_KEY_LO_1);
        wr_reg(OSCSW_ADDR_UNLOCK, 16'h1234);
        wr_reg(OSCSW_ADDR_UNLOCK, OSCSW_KEY_LO_2);
        wr_reg(OSCSW_ADDR_OSC_CTRL, 16'h0000);
        rd_reg(OSCSW_ADDR_OSC_CTRL); chk(v & 16'h0002, 16'h0002);
        osc_wr(1'b0, 16'h0000);
        wait_n(3); chk({15'h0000, osc_en.sec_on}, 16'h0000);
        osc_wr(1'b1, 16'h0000);
        osc_wr(1'b0, 16'h0001);
        wait_n(2); chk({15'h0000, switch_busy}, 16'h0000);
        rd_reg(OSCSW_ADDR_OSC_CTRL); chk(v & 16'h0001, 16'h0000);
        $display("test unlock and redundant switch done");
    endtask
    task automatic t_switch();
        fail_ev <= 1'b1;
        wait_n(1);
        fail_ev <= 1'b0;
        rd_reg(OSCSW_ADDR_OSC_CTRL); chk(v & 16'h0008, 16'h0008);
        // Plain fast RC to primary with PLL is a legal direct hop
        osc_wr(1'b1, 16'h0300);
        rd_reg(OSCSW_ADDR_OSC_CTRL); chk(v & 16'h0700, 16'h0300);
        // Fail bit written as one so only the switch start can clear it
        osc_wr(1'b0, 16'h0009);
        wait_n(2); chk({15'h0000, switch_busy}, 16'h0001);
        rd_reg(OSCSW_ADDR_OSC_CTRL); chk(v & 16'h0029, 16'h0001);
        ticks(12); chk({15'h0000, switch_busy}, 16'h0001);
        chk({14'h0000, osc_en.pri_on, osc_en.pll_on}, 16'h0003);
        ost_done <= 1'b1;
        ticks(12); chk({15'h0000, switch_busy}, 16'h0001);
        pll_lk <= 1'b1;
        wait_n(3);
        ticks(9); chk({15'h0000, switch_busy}, 16'h0001);
        ticks(1);
        wait_n(2); chk({15'h0000, switch_busy}, 16'h0000);
        rd_reg(OSCSW_ADDR_OSC_CTRL); chk(v & 16'h7001, 16'h3000);
        chk({13'h0000, sys_clk_sel}, 16'h0003);
        chk({14'h0000, osc_en.rc_on, osc_en.low_power_rc_oscillator_on}, 16'h0001);
        osc_wr(1'b0, 16'h0080);
        osc_wr(1'b1, 16'h0500);
        rd_reg(OSCSW_ADDR_OSC_CTRL); chk(v & 16'h0700, 16'h0300);
        $display("test clock switch done");
    endtask
    task automatic t_disabled();
        do_reset(1'b1, OSCSW_SRC_PRI);
        chk({13'h0000, sys_clk_sel}, 16'h0002);
        rd_reg(OSCSW_ADDR_OSC_CTRL); chk(v & 16'h7000, 16'h2000);
        osc_wr(1'b1, 16'h0400);
        osc_wr(1'b0, 16'h0001);
        wait_n(2); chk({15'h0000, switch_busy}, 16'h0000);
        rd_reg(OSCSW_ADDR_OSC_CTRL); chk(v & 16'h0001, 16'h0000);
        chk({13'h0000, sys_clk_sel}, 16'h0002);
        fail_ev <= 1'b1;
        wait_n(1);
        fail_ev <= 1'b0;
        rd_reg(OSCSW_ADDR_OSC_CTRL); chk(v & 16'h0008, 16'h0000);
        $display("test switching disabled done");
    endtask
    initial begin
        do_reset(1'b0, OSCSW_SRC_RC);
        t_reset();
        t_div();
        t_roi(16'hB800, 16'h0001);
        t_roi(16'h3800, 16'h0008);
        t_unlock();
        t_switch();
        t_disabled();
        end_sim();
    end
endmodule
`default_nettype wire
